// ===== bench/tb.sv
`timescale 1ns/100ps
module tb;
  logic clk_i = 1'h0;
  logic arst_n_i = 1'h0;
  logic stp_i, dir_o, nxt_o, data_oe_o, tx_valid_o, tx_first_o, tx_stop_o, abort_o, lowpower_o;
  logic [7:0] data_i, data_o, tx_data_o;
  logic tx_ready_i = 1'h0, rx_active_i = 1'h0, rx_valid_i = 1'h0, status_change_i = 1'h0;
  logic rd_valid_i = 1'h0, suspend_req_i = 1'h0, irq_i = 1'h0, go = 1'h0, stp_req = 1'h0;
  logic [7:0] rx_data_i = 8'h00, rd_data_i = 8'h00, status_i = 8'h5a, exp_tx = 8'h41, tx_seen = 8'h00;
  logic [7:0] stops = 8'h00;
  logic [7:0] firsts = 8'h00;
  logic [1:0] line_level_i = 2'h0;
  logic [1:0] kind [3] = '{2'h0, 2'h1, 2'h2};
  logic [7:0] val [3] = '{8'h5a, 8'h3c, 8'ha5};
  logic nxt_exp [3] = '{1'h0, 1'h0, 1'h1};
  int bad_count = 0;
  int compares = 0;

  ulpi_phy_bus i_ulpi_phy_bus (.clk_i(clk_i), .arst_n_i(arst_n_i), .stp_i(stp_i), .data_i(data_i),
    .data_o(data_o), .data_oe_o(data_oe_o), .dir_o(dir_o), .nxt_o(nxt_o), .tx_ready_i(tx_ready_i),
    .tx_data_o(tx_data_o), .tx_valid_o(tx_valid_o), .tx_first_o(tx_first_o), .tx_stop_o(tx_stop_o),
    .rx_active_i(rx_active_i), .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i), .abort_o(abort_o),
    .status_i(status_i), .status_change_i(status_change_i), .rd_valid_i(rd_valid_i),
    .rd_data_i(rd_data_i), .suspend_req_i(suspend_req_i), .line_level_i(line_level_i),
    .irq_i(irq_i), .lowpower_o(lowpower_o));
  usb_link_model i_usb_link_model (.clk_i(clk_i), .arst_n_i(arst_n_i), .dir_i(dir_o), .nxt_i(nxt_o),
    .data_o(data_i), .stp_o(stp_i), .cmd_i(8'h41), .len_i(4'h3), .go_i(go), .stp_req_i(stp_req));

  always #25 clk_i = ~clk_i;

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Turnaround and idle cycles never match, since the driver must be on
  task automatic wait_byte(input logic [7:0] exp);
    for (int n = 0; n < 12; n++) begin
      @(negedge clk_i);
      if (dir_o === 1'h1 && data_oe_o === 1'h1 && data_o === exp) break;
    end
    chk("bus byte", exp, data_o);
  endtask

  task automatic stop_test;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Outputs are looked at on the falling edge, where they have settled
  always @(negedge clk_i) begin
    if (tx_valid_o === 1'h1) begin
      chk("tx byte", exp_tx, tx_data_o);
      exp_tx <= exp_tx + 8'h01;
      tx_seen <= tx_seen + 8'h01;
    end
    if (tx_first_o === 1'h1) begin
      chk("first byte", 8'h41, tx_data_o);
      firsts <= firsts + 8'h01;
    end
    if (tx_stop_o === 1'h1) stops <= stops + 8'h01;
  end

  initial begin
    #400000;
    bad_count++;
    stop_test();
  end

  initial begin
    repeat (10) @(negedge clk_i);
    arst_n_i = 1'h1;
    @(negedge clk_i);
    chk("reset dir", 8'h00, {7'h0, dir_o});
    chk("reset nxt", 8'h00, {7'h0, nxt_o});
    $display("reset test done");
    for (int r = 0; r < 3; r++) begin
      if (kind[r] == 2'h0) status_change_i = 1'h1;
      else if (kind[r] == 2'h1) rd_valid_i = 1'h1;
      else rx_active_i = 1'h1;
      rd_data_i = val[r];
      @(negedge clk_i);
      status_change_i = 1'h0;
      rd_valid_i = 1'h0;
      if (kind[r] == 2'h2) begin
        wait_byte(8'h5a);
        rx_valid_i = 1'h1;
        rx_data_i = val[r];
        @(negedge clk_i);
        rx_valid_i = 1'h0;
      end
      wait_byte(val[r]);
      chk("nxt", {7'h0, nxt_exp[r]}, {7'h0, nxt_o});
      rx_active_i = 1'h0;
      repeat (8) @(negedge clk_i);
      chk("dir idle", 8'h00, {7'h0, dir_o});
      $display("row %0d done", r);
    end
    go = 1'h1;
    @(negedge clk_i);
    go = 1'h0;
    repeat (4) @(negedge clk_i);
    chk("nxt stalled", 8'h00, {7'h0, nxt_o});
    tx_ready_i = 1'h1;
    repeat (12) @(negedge clk_i);
    chk("tx count", 8'h04, tx_seen);
    chk("tx stops", 8'h01, stops);
    chk("tx firsts", 8'h01, firsts);
    $display("transmit test done");
    rx_active_i = 1'h1;
    for (int n = 0; n < 6 && dir_o !== 1'h1; n++) @(negedge clk_i);
    stp_req = 1'h1;
    rx_active_i = 1'h0;
    @(negedge clk_i);
    stp_req = 1'h0;
    chk("abort dir", 8'h00, {7'h0, dir_o});
    chk("abort flag", 8'h01, {7'h0, abort_o});
    repeat (6) @(negedge clk_i);
    $display("abort test done");
    // Suspend request stands for the link clearing the suspend bit
    suspend_req_i = 1'h1;
    for (int n = 0; n < 6 && lowpower_o !== 1'h1; n++) @(negedge clk_i);
    chk("lp dir", 8'h01, {7'h0, dir_o});
    chk("lp flag", 8'h01, {7'h0, lowpower_o});
    chk("lp oe", 8'h01, {7'h0, data_oe_o});
    chk("lp nxt", 8'h00, {7'h0, nxt_o});
    for (int i = 0; i < 8; i++) begin
      @(negedge clk_i);
      line_level_i = i[1:0];
      irq_i = i[2];
      #1;
      chk("lp bus", {4'h0, i[2], 1'h0, i[1:0]}, data_o);
    end
    repeat (4) @(negedge clk_i);
    // Clock keeps running, so it is live before the wake
    stp_req = 1'h1;
    suspend_req_i = 1'h0;
    for (int n = 0; n < 6 && lowpower_o !== 1'h0; n++) @(negedge clk_i);
    stp_req = 1'h0;
    chk("wake dir", 8'h00, {7'h0, dir_o});
    chk("wake lp", 8'h00, {7'h0, lowpower_o});
    wait_byte(8'h5a);
    chk("wake nxt", 8'h00, {7'h0, nxt_o});
    $display("low power test done");
    stop_test();
  end
endmodule

// ===== bench/usb_link_model.sv
`timescale 1ns/100ps
module usb_link_model (
  // Clock, reset and bus
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic dir_i,
  input wire logic nxt_i,
  output logic [7:0] data_o,
  output logic stp_o,
  // Bench control
  input wire logic [7:0] cmd_i,
  input wire logic [3:0] len_i,
  input wire logic go_i,
  input wire logic stp_req_i
);
  logic busy_q;
  logic end_q;
  logic [3:0] left_q;
  logic [7:0] byte_q;
  // Released bus shows the inverse, never a stale copy of the last byte
  assign data_o = dir_i ? ~byte_q : byte_q;
  assign stp_o = stp_req_i | end_q;
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      busy_q <= 1'h0;
      end_q <= 1'h0;
      left_q <= 4'h0;
      byte_q <= 8'h00;
    end else begin
      end_q <= 1'h0;
      if (go_i && !busy_q && !dir_i) begin
        busy_q <= 1'h1;
        byte_q <= cmd_i;
        left_q <= len_i;
      end else if (busy_q && nxt_i && !dir_i && !end_q) begin
        // Byte taken at this edge, so the next one follows, or STP after the last
        if (left_q == 4'h0) begin
          end_q <= 1'h1;
          busy_q <= 1'h0;
          byte_q <= 8'h00;
        end else begin
          byte_q <= byte_q + 8'h01;
          left_q <= left_q - 4'h1;
        end
      end
    end
  end
endmodule

// ===== core/ulpi_phy_bus.sv
`timescale 1ns/100ps
module ulpi_phy_bus (
  // Interface clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Bus pins facing the link
  input wire logic stp_i,
  input wire logic [ulpi_pkg::DATA_W-1:0] data_i,
  output logic [ulpi_pkg::DATA_W-1:0] data_o,
  output logic data_oe_o,
  output logic dir_o,
  output logic nxt_o,
  // Transmit stream towards the serialiser
  input wire logic tx_ready_i,
  output logic [ulpi_pkg::DATA_W-1:0] tx_data_o,
  output logic tx_valid_o,
  output logic tx_first_o,
  output logic tx_stop_o,
  // Receive stream from the deserialiser
  input wire logic rx_active_i,
  input wire logic rx_valid_i,
  input wire logic [ulpi_pkg::DATA_W-1:0] rx_data_i,
  output logic abort_o,
  // Status and register read
  input wire logic [ulpi_pkg::DATA_W-1:0] status_i,
  input wire logic status_change_i,
  input wire logic rd_valid_i,
  input wire logic [ulpi_pkg::DATA_W-1:0] rd_data_i,
  // Low-power control and analog levels
  input wire logic suspend_req_i,
  input wire logic [ulpi_pkg::LINE_HI:ulpi_pkg::LINE_LO] line_level_i,
  input wire logic irq_i,
  output logic lowpower_o
);
  typedef struct packed {
    ulpi_pkg::state_t st;
    logic dir;
    logic nxt;
    logic oe;
    logic lp;
    logic [ulpi_pkg::DATA_W-1:0] data;
    logic in_tx;
    logic first_pend;
    logic [ulpi_pkg::DATA_W-1:0] tx_data;
    logic tx_valid;
    logic tx_first;
    logic tx_stop;
    logic abort;
    logic [ulpi_pkg::DATA_W-1:0] rx_hold;
    logic rx_hold_v;
    logic status_pend;
    logic rd_pend;
    logic [ulpi_pkg::DATA_W-1:0] rd_byte;
    logic susp_prev;
    logic irq_base;
  } phy_t;

  phy_t q, d;
  logic irq_s;
  logic want_out;
  logic [ulpi_pkg::DATA_W-1:0] lp_byte;

  // Interrupt level feeds clocked logic, so it is synchronised first
  bit_sync #(
    .W(1)
  ) irq_sync (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .d_i(irq_i),
    .q_o(irq_s)
  );

  // Anything that must reach the link turns the bus round
  assign want_out = rx_active_i | q.rx_hold_v | q.status_pend | q.rd_pend | rd_valid_i | status_change_i;

  always_comb begin
    d = q;
    d.tx_valid = 1'b0;
    d.tx_first = 1'b0;
    d.tx_stop = 1'b0;
    d.abort = 1'b0;
    d.nxt = 1'b0;
    d.susp_prev = suspend_req_i;
    // Everything below launches on the rising edge of clk_i, as the link samples
    unique case (q.st)
      ulpi_pkg::S_LISTEN: begin
        d.dir = 1'b0;
        d.oe = 1'b0;
        if (q.in_tx) begin
          if (stp_i) begin
            d.in_tx = 1'b0;
            d.tx_stop = 1'b1;
          end else begin
            if (q.nxt) begin
              d.tx_valid = 1'b1;
              d.tx_data = data_i;
              d.tx_first = q.first_pend;
              d.first_pend = 1'b0;
            end
            d.nxt = tx_ready_i;
          end
        end else if (data_i != ulpi_pkg::IDLE_BYTE) begin
          // Link holds its command until NXT takes it
          d.in_tx = 1'b1;
          d.first_pend = 1'b1;
          d.nxt = tx_ready_i;
        end else if (suspend_req_i && !q.susp_prev) begin
          d.st = ulpi_pkg::S_LP_TURN;
          d.dir = 1'b1;
        end else if (want_out) begin
          d.st = ulpi_pkg::S_TURN_OUT;
          d.dir = 1'b1;
        end
      end
      ulpi_pkg::S_TURN_OUT: begin
        if (stp_i) begin
          d.st = ulpi_pkg::S_TURN_IN;
          d.dir = 1'b0;
          d.abort = 1'b1;
        end else begin
          // Turnaround: bus content is meaningless to the link
          d.st = ulpi_pkg::S_SEND;
          d.oe = 1'b1;
          d.data = ulpi_pkg::IDLE_BYTE;
        end
      end
      ulpi_pkg::S_SEND: begin
        if (stp_i) begin
          d.st = ulpi_pkg::S_TURN_IN;
          d.dir = 1'b0;
          d.oe = 1'b0;
          d.abort = 1'b1;
          d.rx_hold_v = 1'b0;
        end else if (q.rd_pend) begin
          d.data = q.rd_byte;
          d.rd_pend = 1'b0;
        end else if (q.rx_hold_v) begin
          d.data = q.rx_hold;
          d.nxt = 1'b1;
          d.rx_hold_v = 1'b0;
        end else if (rx_active_i || q.status_pend) begin
          d.data = status_i;
          d.status_pend = 1'b0;
        end else begin
          d.st = ulpi_pkg::S_TURN_IN;
          d.dir = 1'b0;
          d.oe = 1'b0;
        end
      end
      ulpi_pkg::S_TURN_IN: begin
        // Link-driven turnaround; a late STP of a wake is also swallowed here
        d.st = ulpi_pkg::S_LISTEN;
        d.data = ulpi_pkg::IDLE_BYTE;
      end
      ulpi_pkg::S_LP_TURN: begin
        d.st = ulpi_pkg::S_LP;
        d.oe = 1'b1;
        d.lp = 1'b1;
        d.data = ulpi_pkg::IDLE_BYTE;
        d.irq_base = irq_s;
      end
      ulpi_pkg::S_LP: begin
        d.dir = 1'b1;
        // The clock may be stopped here; nothing advances until it runs again
        if (stp_i) begin
          d.st = ulpi_pkg::S_TURN_IN;
          d.dir = 1'b0;
          d.oe = 1'b0;
          d.lp = 1'b0;
          if (irq_s != q.irq_base) begin
            d.status_pend = 1'b1;
          end
        end
      end
      default: begin
        d.st = ulpi_pkg::S_LISTEN;
        d.dir = 1'b0;
        d.oe = 1'b0;
        d.lp = 1'b0;
      end
    endcase
    // New events win over the clears above
    if (status_change_i) begin
      d.status_pend = 1'b1;
    end
    if (rd_valid_i) begin
      d.rd_pend = 1'b1;
      d.rd_byte = rd_data_i;
    end
    if (rx_valid_i) begin
      d.rx_hold = rx_data_i;
      d.rx_hold_v = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Low-power remap is deliberately unclocked so line levels pass with the clock stopped
  always_comb begin
    lp_byte = ulpi_pkg::IDLE_BYTE;
    lp_byte[ulpi_pkg::LINE_HI:ulpi_pkg::LINE_LO] = line_level_i;
    lp_byte[ulpi_pkg::LP_INT_BIT] = irq_i;
  end

  assign data_o = q.lp ? lp_byte : q.data;
  assign data_oe_o = q.oe;
  assign dir_o = q.dir;
  assign nxt_o = q.nxt;
  assign tx_data_o = q.tx_data;
  assign tx_valid_o = q.tx_valid;
  assign tx_first_o = q.tx_first;
  assign tx_stop_o = q.tx_stop;
  assign abort_o = q.abort;
  assign lowpower_o = q.lp;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!arst_n_i);

  sequence wake_seq;
    (q.st == ulpi_pkg::S_LP) && stp_i;
  endsequence

  sequence back_to_listen;
    !dir_o ##1 (q.st == ulpi_pkg::S_LISTEN) && !dir_o;
  endsequence

  listen_dir_low_a: assert property ((q.st == ulpi_pkg::S_LISTEN) |-> !dir_o && !data_oe_o)
    else $error("DIR high while listening");
  dir_cause_a: assert property ($rose(dir_o) |-> $past(want_out) || $past(suspend_req_i))
    else $error("DIR raised with nothing to send");
  rx_byte_a: assert property (dir_o && nxt_o |-> $past(q.rx_hold_v) && data_o == $past(q.rx_hold))
    else $error("NXT high without receive byte");
  status_byte_a: assert property ($past(q.st == ulpi_pkg::S_SEND) && $past(!stp_i) && $past(!q.rd_pend)
      && $past(!q.rx_hold_v) && dir_o |-> !nxt_o && data_o == $past(status_i))
    else $error("Wrong status byte");
  read_byte_a: assert property ((q.st == ulpi_pkg::S_SEND) && q.rd_pend && !stp_i
      |=> !nxt_o && dir_o && data_o == $past(q.rd_byte))
    else $error("Read byte not returned");
  lp_dir_high_a: assert property (lowpower_o |-> dir_o && !nxt_o)
    else $error("DIR or NXT wrong in low power");
  abort_dir_a: assert property (dir_o && stp_i && (q.st inside {ulpi_pkg::S_TURN_OUT, ulpi_pkg::S_SEND})
      |=> !dir_o && abort_o)
    else $error("Abort did not drop DIR");
  wake_exit_a: assert property (wake_seq |=> back_to_listen)
    else $error("Wake did not return to sync mode");
  tx_take_a: assert property ((q.st == ulpi_pkg::S_LISTEN) && q.in_tx && nxt_o && !stp_i
      |=> tx_valid_o && tx_data_o == $past(data_i))
    else $error("Offered byte not taken");
  lp_map_a: assert property (lowpower_o |-> data_o[ulpi_pkg::LINE_HI:ulpi_pkg::LINE_LO] == line_level_i
      && data_o[ulpi_pkg::LP_INT_BIT] == irq_i && !data_o[ulpi_pkg::LP_RSVD_BIT]
      && data_o[ulpi_pkg::DATA_W-1:ulpi_pkg::LP_INT_BIT+1] == '0)
    else $error("Low-power pin map wrong");
  exit_status_a: assert property (wake_seq and (irq_s != q.irq_base) |=> q.status_pend ##[1:4] (!q.status_pend
      && dir_o))
    else $error("No status after wake");

  // Bus ownership follows the state, so a stray DIR or NXT shows up at once
  turn_out_oe_a: assert property ((q.st == ulpi_pkg::S_TURN_OUT) |-> dir_o && !data_oe_o)
    else $error("Bus driven during turnaround");
  send_drive_a: assert property ((q.st == ulpi_pkg::S_SEND) |-> dir_o && data_oe_o)
    else $error("Bus not driven while sending");
  listen_nxt_a: assert property (!dir_o && nxt_o |-> q.in_tx && (q.st == ulpi_pkg::S_LISTEN))
    else $error("NXT high with no transmit");
  lp_no_nxt_a: assert property ((q.st inside {ulpi_pkg::S_LP_TURN, ulpi_pkg::S_LP}) |-> dir_o && !nxt_o)
    else $error("NXT used in low power");
  idle_drop_a: assert property ((q.st == ulpi_pkg::S_SEND) && !stp_i && !q.rd_pend && !q.rx_hold_v && !rx_active_i
      && !q.status_pend |=> !dir_o && !data_oe_o)
    else $error("DIR kept high with nothing to send");
  abort_pulse_a: assert property (abort_o |-> !dir_o && (q.st == ulpi_pkg::S_TURN_IN))
    else $error("Abort flagged with DIR high");
endmodule

// ===== core/ulpi_pkg_sync.sv
`timescale 1ns/100ps
package ulpi_pkg;
  // Bus width and the low-power remapping of the data pins
  localparam int DATA_W = 8;
  localparam int LINE_LO = 0;
  localparam int LINE_HI = 1;
  localparam int LP_RSVD_BIT = 2;
  localparam int LP_INT_BIT = 3;
  localparam logic [DATA_W-1:0] IDLE_BYTE = 8'h00;
  localparam logic [0:0] SYNC_RST = 1'h0;

  typedef enum logic [2:0] {
    S_LISTEN,
    S_TURN_OUT,
    S_SEND,
    S_TURN_IN,
    S_LP_TURN,
    S_LP
  } state_t;
endpackage

module bit_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Asynchronous level in, synchronous level out
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] safe;
  } sync_t;

  sync_t q, d;

  always_comb begin
    d = q;
    d.meta = d_i;
    d.safe = q.meta;
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign q_o = q.safe;
endmodule
